// *** verilog/bpstep_pkg.sv ***
// Constants, register map and state types for the CPU breakpoint/step unit.
package bpstep_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_CMD = 16'h0000;
    localparam logic [15:0] OFS_MODE = 16'h0004;
    localparam logic [15:0] OFS_BREAK_ADDR = 16'h0008;
    localparam logic [15:0] OFS_STATUS = 16'h000C;
    localparam logic [15:0] OFS_DEBUG_KEY = 16'h0010;
    localparam logic [15:0] OFS_DEBUG_CMD = 16'h0014;
    localparam logic [15:0] OFS_EXT_LO = 16'h0018;
    localparam logic [15:0] OFS_EXT_HI = 16'h001C;
    localparam logic [15:0] OFS_EXT_BASE = 16'h0020;
    localparam logic [15:0] OFS_MEM_BASE = 16'h2000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_PSTEP_BIT = 0;
    localparam int CMD_USTEP_BIT = 1;
    localparam int CMD_MHALT_BIT = 2;
    localparam int CMD_MRUN_BIT = 3;
    localparam int CMD_HALT_BIT = 4;
    localparam int CMD_BPTYPE_LSB = 8;
    localparam int MODE_SW_BIT = 0;
    localparam int MODE_UPD_BIT = 1;
    localparam int DBG_ARM_BIT = 0;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_MICROADDR = 3'h1;
    localparam logic [2:0] BP_MEM_READ = 3'h2;
    localparam logic [2:0] BP_MEM_WRITE = 3'h3;
    localparam logic [2:0] BP_IO_WRITE = 3'h4;
    localparam logic [2:0] BP_IO_READ = 3'h5;
    localparam logic [15:0] UINSTR_RUN_DISABLE = 16'h0401;
    localparam logic [15:0] UINSTR_RUN_ENABLE = 16'h0201;
    localparam logic [7:0] CTRL7_CHAR = 8'h17;
    localparam logic [1:0] UADDR_STOP_DELAY = 2'h3;
    localparam logic MODE_SW_RESET = 1'b0;
    localparam logic MODE_UPD_RESET = 1'b1;

    // ------------------------------------------------------------
    // Maintenance memory layout (word addresses)
    // ------------------------------------------------------------
    localparam int MEM_AW = 11;
    localparam int MEM_DW = 16;
    localparam logic [10:0] FAIL_BUF_BASE = 11'h700;
    localparam logic [7:0] FAIL_BUF_LAST = 8'hFF;

    typedef enum logic [2:0] {
        PS_IDLE, PS_HALT_WAIT, PS_FORCE1, PS_FORCE2, PS_TOGGLE, PS_RELEASE
    } ps_state_t;

    typedef enum logic [1:0] {
        ME_IDLE, ME_CLEAR, ME_COPY_RD, ME_COPY_WR
    } mem_state_t;

endpackage

// *** verilog/maint_memory.sv ***
// Single-port maintenance processor memory with a registered read port.
`timescale 1ns/100ps
module maint_memory #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// *** verilog/cpu_breakpoint_step_control.sv ***
// CPU program/micro step sequencer and single-address breakpoint unit.
//
// Behaviour
// - Program step ignored while CPU runs or is already microhalted.
// - Program step microhalts, then forces 0401 and 0201 microinstructions.
// - Then pulses run-toggle and returns the CPU to microrun.
// - Debug commands accepted only right after a control-7 key.
// - Eight external registers, each writable, readable four per word.
// - Arm clears 700-7FF; first failure copies stack there, once.
// - Issuing a breakpoint type toggles it off or enables it.
// - One type at a time; halt needs loaded address and a type.
// - Types: microaddress, memory read/write, I/O write/read.
// - Microaddress breakpoint refused in software view mode.
// - Microaddress match stops the CPU three microinstructions later.
// - Memory breakpoint microhalts on access in selected direction.
// - Matching sees every requester's access, not only the CPU.
// - Program halt then microrun completes the unfinished instruction.
// - Software mode lets the current instruction usually complete.
// - Microstep refused while display updates are enabled.
// - Microstep is one major cycle, only when microhalted, timers off.
// - In software mode every match sets program halt, not microhalt.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module cpu_breakpoint_step_control #(
    parameter int AW = 16,
    parameter int EXT_W = 8
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic CPU_RUN_IN,
    input wire logic CPU_MHALT_IN,
    input wire logic [AW-1:0] UADDR_IN,
    input wire logic UADDR_VALID_IN,
    input wire logic [AW-1:0] BUS_ADDR_IN,
    input wire logic MEM_RD_IN,
    input wire logic MEM_WR_IN,
    input wire logic IO_RD_IN,
    input wire logic IO_WR_IN,
    input wire logic TEST_FAIL_IN,
    output logic MHALT_OUT,
    output logic [15:0] FORCE_UINSTR_OUT,
    output logic FORCE_VALID_OUT,
    output logic TOGGLE_RUN_OUT,
    output logic SET_HALT_OUT,
    output logic USTEP_OUT,
    output logic TIMER_SUPPRESS_OUT,
    output logic [8*EXT_W-1:0] EXT_REGS_OUT
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bpstep_pkg::ps_state_t ps;
        bpstep_pkg::mem_state_t me;
        logic hold;
        logic [15:0] force_word;
        logic force_valid;
        logic toggle_run;
        logic set_halt;
        logic ustep;
        logic suppress;
        logic sw_mode;
        logic upd_en;
        logic [AW-1:0] bp_addr;
        logic bp_loaded;
        logic [2:0] bp_type;
        logic [1:0] ucount;
        logic ucount_run;
        logic key_ok;
        logic armed;
        logic [7:0] idx;
        logic [7:0][EXT_W-1:0] ext;
        logic [31:0] rdata;
        logic rd_mem;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic mem_we;
    logic [bpstep_pkg::MEM_AW-1:0] mem_addr;
    logic [bpstep_pkg::MEM_DW-1:0] mem_wdata;
    logic [bpstep_pkg::MEM_DW-1:0] mem_rdata;
    logic wr_cmd;
    logic is_mem;
    logic bp_hit;
    logic uaddr_match;
    logic [2:0] req_type;

    maint_memory #(
        .AW(bpstep_pkg::MEM_AW),
        .DW(bpstep_pkg::MEM_DW)
    ) u_mem (
        .clk_in(CLK_IN),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    assign wr_cmd = WR_IN && (ADDR_IN == bpstep_pkg::OFS_CMD);
    assign is_mem = ADDR_IN[13];
    assign req_type = WDATA_IN[bpstep_pkg::CMD_BPTYPE_LSB +: 3];

    // ------------------------------------------------------------
    // Breakpoint compare
    // ------------------------------------------------------------
    // Every requester drives the same bus, so any access is seen.
    always_comb begin
        bp_hit = 1'b0;
        uaddr_match = 1'b0;
        if (s_reg.bp_loaded) begin
            case (s_reg.bp_type)
                bpstep_pkg::BP_MICROADDR: begin
                    uaddr_match = UADDR_VALID_IN
                        && (UADDR_IN == s_reg.bp_addr);
                end
                bpstep_pkg::BP_MEM_READ: begin
                    bp_hit = MEM_RD_IN && (BUS_ADDR_IN == s_reg.bp_addr);
                end
                bpstep_pkg::BP_MEM_WRITE: begin
                    bp_hit = MEM_WR_IN && (BUS_ADDR_IN == s_reg.bp_addr);
                end
                bpstep_pkg::BP_IO_WRITE: begin
                    bp_hit = IO_WR_IN
                        && (BUS_ADDR_IN == s_reg.bp_addr);
                end
                bpstep_pkg::BP_IO_READ: begin
                    bp_hit = IO_RD_IN
                        && (BUS_ADDR_IN == s_reg.bp_addr);
                end
                default: begin
                    bp_hit = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.force_valid = 1'b0;
        s_next.toggle_run = 1'b0;
        s_next.set_halt = 1'b0;
        s_next.ustep = 1'b0;
        s_next.rd_mem = 1'b0;
        s_next.rdata = 32'h00000000;
        mem_we = 1'b0;
        mem_addr = ADDR_IN[2 +: bpstep_pkg::MEM_AW];
        mem_wdata = WDATA_IN[bpstep_pkg::MEM_DW-1:0];

        // Program step sequence.
        case (s_reg.ps)
            bpstep_pkg::PS_IDLE: begin
                if (wr_cmd && WDATA_IN[bpstep_pkg::CMD_PSTEP_BIT]
                    && !CPU_RUN_IN && !CPU_MHALT_IN) begin
                    s_next.hold = 1'b1;
                    s_next.ps = bpstep_pkg::PS_HALT_WAIT;
                end
            end
            bpstep_pkg::PS_HALT_WAIT: begin
                if (CPU_MHALT_IN) begin
                    s_next.ps = bpstep_pkg::PS_FORCE1;
                end
            end
            bpstep_pkg::PS_FORCE1: begin
                s_next.force_word = bpstep_pkg::UINSTR_RUN_DISABLE;
                s_next.force_valid = 1'b1;
                s_next.ps = bpstep_pkg::PS_FORCE2;
            end
            bpstep_pkg::PS_FORCE2: begin
                s_next.force_word = bpstep_pkg::UINSTR_RUN_ENABLE;
                s_next.force_valid = 1'b1;
                s_next.ps = bpstep_pkg::PS_TOGGLE;
            end
            bpstep_pkg::PS_TOGGLE: begin
                // An interruptible instruction may stop partway.
                s_next.toggle_run = 1'b1;
                s_next.ps = bpstep_pkg::PS_RELEASE;
            end
            bpstep_pkg::PS_RELEASE: begin
                s_next.hold = 1'b0;
                s_next.ps = bpstep_pkg::PS_IDLE;
            end
            default: begin
                s_next.ps = bpstep_pkg::PS_IDLE;
            end
        endcase

        // Control commands; microhalt and microrun are refused in software mode.
        if (wr_cmd) begin
            if (WDATA_IN[bpstep_pkg::CMD_USTEP_BIT] && CPU_MHALT_IN
                && !s_reg.upd_en) begin
                s_next.ustep = 1'b1;
            end
            if (WDATA_IN[bpstep_pkg::CMD_HALT_BIT]) begin
                s_next.set_halt = 1'b1;
            end
            if (!s_reg.sw_mode && s_reg.ps == bpstep_pkg::PS_IDLE) begin
                if (WDATA_IN[bpstep_pkg::CMD_MHALT_BIT]) begin
                    s_next.hold = 1'b1;
                end else if (WDATA_IN[bpstep_pkg::CMD_MRUN_BIT]) begin
                    s_next.hold = 1'b0;
                end
            end
            if (req_type != bpstep_pkg::BP_NONE
                && req_type <= bpstep_pkg::BP_IO_READ) begin
                if (req_type == s_reg.bp_type) begin
                    s_next.bp_type = bpstep_pkg::BP_NONE;
                end else if (!(s_reg.sw_mode
                    && req_type == bpstep_pkg::BP_MICROADDR)) begin
                    s_next.bp_type = req_type;
                    s_next.ucount_run = 1'b0;
                end
            end
        end
        if (WR_IN && ADDR_IN == bpstep_pkg::OFS_MODE) begin
            s_next.sw_mode = WDATA_IN[bpstep_pkg::MODE_SW_BIT];
            s_next.upd_en = WDATA_IN[bpstep_pkg::MODE_UPD_BIT];
            if (WDATA_IN[bpstep_pkg::MODE_SW_BIT]
                && s_next.bp_type == bpstep_pkg::BP_MICROADDR) begin
                s_next.bp_type = bpstep_pkg::BP_NONE;
            end
        end
        if (WR_IN && ADDR_IN == bpstep_pkg::OFS_BREAK_ADDR) begin
            s_next.bp_addr = WDATA_IN[AW-1:0];
            s_next.bp_loaded = 1'b1;
        end

        // Microaddress breakpoint: count three more microinstructions.
        if (s_reg.ucount_run) begin
            if (s_reg.ucount == 2'h0) begin
                s_next.hold = 1'b1;
                s_next.ucount_run = 1'b0;
            end else if (UADDR_VALID_IN) begin
                s_next.ucount = s_reg.ucount - 2'h1;
            end
        end else if (uaddr_match) begin
            s_next.ucount = bpstep_pkg::UADDR_STOP_DELAY;
            s_next.ucount_run = 1'b1;
        end

        // Bus breakpoints: software mode takes the program halt path.
        if (bp_hit) begin
            if (s_reg.sw_mode) begin
                s_next.set_halt = 1'b1;
            end else begin
                s_next.hold = 1'b1;
            end
        end
        // Taken after every source of hold, so timers stop in the same cycle.
        s_next.suppress = s_next.hold || s_next.ustep;

        // Debug commands need the control-7 key written just before.
        if (WR_IN && ADDR_IN == bpstep_pkg::OFS_DEBUG_KEY) begin
            s_next.key_ok = (WDATA_IN[7:0] == bpstep_pkg::CTRL7_CHAR);
        end else if (WR_IN) begin
            s_next.key_ok = 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            if (WR_IN && s_reg.key_ok && ADDR_IN == bpstep_pkg::OFS_EXT_BASE
                + 16'(4 * i)) begin
                s_next.ext[i] = WDATA_IN[EXT_W-1:0];
            end
        end

        // Failure buffer engine owns the memory port while busy.
        case (s_reg.me)
            bpstep_pkg::ME_IDLE: begin
                if (WR_IN && s_reg.key_ok
                    && ADDR_IN == bpstep_pkg::OFS_DEBUG_CMD
                    && WDATA_IN[bpstep_pkg::DBG_ARM_BIT]) begin
                    s_next.me = bpstep_pkg::ME_CLEAR;
                    s_next.idx = 8'h00;
                    s_next.armed = 1'b0;
                end else if (TEST_FAIL_IN && s_reg.armed) begin
                    s_next.me = bpstep_pkg::ME_COPY_RD;
                    s_next.idx = 8'h00;
                    s_next.armed = 1'b0;
                end else if (is_mem && (WR_IN || RD_IN)) begin
                    mem_we = WR_IN;
                    s_next.rd_mem = RD_IN;
                end
            end
            bpstep_pkg::ME_CLEAR: begin
                mem_we = 1'b1;
                mem_addr = bpstep_pkg::FAIL_BUF_BASE
                    + {3'h0, s_reg.idx};
                mem_wdata = 16'h0000;
                s_next.idx = s_reg.idx + 8'h01;
                if (s_reg.idx == bpstep_pkg::FAIL_BUF_LAST) begin
                    s_next.me = bpstep_pkg::ME_IDLE;
                    s_next.armed = 1'b1;
                end
            end
            bpstep_pkg::ME_COPY_RD: begin
                mem_addr = {3'h0, s_reg.idx};
                s_next.me = bpstep_pkg::ME_COPY_WR;
            end
            bpstep_pkg::ME_COPY_WR: begin
                mem_we = 1'b1;
                mem_addr = bpstep_pkg::FAIL_BUF_BASE
                    + {3'h0, s_reg.idx};
                mem_wdata = mem_rdata;
                s_next.idx = s_reg.idx + 8'h01;
                s_next.me = (s_reg.idx == bpstep_pkg::FAIL_BUF_LAST)
                    ? bpstep_pkg::ME_IDLE : bpstep_pkg::ME_COPY_RD;
            end
            default: begin
                s_next.me = bpstep_pkg::ME_IDLE;
            end
        endcase

        // Register read path; data appear in the next cycle only.
        if (RD_IN && !is_mem) begin
            case (ADDR_IN)
                bpstep_pkg::OFS_MODE: begin
                    s_next.rdata = {30'h0, s_reg.upd_en,
                        s_reg.sw_mode};
                end
                bpstep_pkg::OFS_BREAK_ADDR: begin
                    s_next.rdata = 32'(s_reg.bp_addr);
                end
                bpstep_pkg::OFS_STATUS: begin
                    s_next.rdata = {20'h00000, s_reg.me != bpstep_pkg::ME_IDLE,
                        s_reg.armed, CPU_MHALT_IN, CPU_RUN_IN, s_reg.hold,
                        s_reg.ps != bpstep_pkg::PS_IDLE, s_reg.bp_loaded,
                        s_reg.ucount_run, 1'b0, s_reg.bp_type};
                end
                bpstep_pkg::OFS_EXT_LO: begin
                    s_next.rdata = 32'(s_reg.ext[3:0]);
                end
                bpstep_pkg::OFS_EXT_HI: begin
                    s_next.rdata = 32'(s_reg.ext[7:4]);
                end
                default: begin
                    s_next.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            s_reg <= '0;
            s_reg.sw_mode <= bpstep_pkg::MODE_SW_RESET;
            s_reg.upd_en <= bpstep_pkg::MODE_UPD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Memory reads come from the memory's own output register.
    assign RDATA_OUT = s_reg.rd_mem ? 32'(mem_rdata) : s_reg.rdata;
    assign MHALT_OUT = s_reg.hold;
    assign FORCE_UINSTR_OUT = s_reg.force_word;
    assign FORCE_VALID_OUT = s_reg.force_valid;
    assign TOGGLE_RUN_OUT = s_reg.toggle_run;
    assign SET_HALT_OUT = s_reg.set_halt;
    assign USTEP_OUT = s_reg.ustep;
    assign TIMER_SUPPRESS_OUT = s_reg.suppress;
    assign EXT_REGS_OUT = s_reg.ext;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ps_ignored;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (s_reg.ps == bpstep_pkg::PS_IDLE && wr_cmd
            && WDATA_IN[bpstep_pkg::CMD_PSTEP_BIT]
            && (CPU_RUN_IN || CPU_MHALT_IN))
            |=> s_reg.ps == bpstep_pkg::PS_IDLE;
    endproperty
    a_ps_ignored: assert property (p_ps_ignored)
        else $error("Program step accepted while running or microhalted.");

    property p_force_pair;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (FORCE_VALID_OUT
            && FORCE_UINSTR_OUT == bpstep_pkg::UINSTR_RUN_DISABLE)
            |=> FORCE_VALID_OUT
            && FORCE_UINSTR_OUT == bpstep_pkg::UINSTR_RUN_ENABLE;
    endproperty
    a_force_pair: assert property (p_force_pair)
        else $error("Second forced microinstruction missing.");

    property p_toggle_after_force;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (FORCE_VALID_OUT
            && FORCE_UINSTR_OUT == bpstep_pkg::UINSTR_RUN_ENABLE)
            |=> TOGGLE_RUN_OUT ##1 !TOGGLE_RUN_OUT;
    endproperty
    a_toggle_after_force: assert property (p_toggle_after_force)
        else $error("Run toggle pulse not one cycle after forcing.");

    property p_ustep_gate;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        USTEP_OUT |-> $past(CPU_MHALT_IN) && !$past(s_reg.upd_en)
            && TIMER_SUPPRESS_OUT ##1 !USTEP_OUT;
    endproperty
    a_ustep_gate: assert property (p_ustep_gate)
        else $error("Microstep issued while refused or too long.");

    property p_hit_needs_setup;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (bp_hit || uaddr_match) |-> s_reg.bp_loaded
            && s_reg.bp_type != bpstep_pkg::BP_NONE;
    endproperty
    a_hit_needs_setup: assert property (p_hit_needs_setup)
        else $error("Breakpoint hit without address or type.");

    property p_no_uaddr_sw;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        s_reg.sw_mode |-> s_reg.bp_type != bpstep_pkg::BP_MICROADDR;
    endproperty
    a_no_uaddr_sw: assert property (p_no_uaddr_sw)
        else $error("Microaddress breakpoint active in software mode.");

    property p_hw_mem_halt;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (bp_hit && !s_reg.sw_mode) |=> MHALT_OUT;
    endproperty
    a_hw_mem_halt: assert property (p_hw_mem_halt)
        else $error("Hardware mode hit did not microhalt.");

    property p_sw_prog_halt;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (bp_hit && s_reg.sw_mode) |=> SET_HALT_OUT && $stable(MHALT_OUT);
    endproperty
    a_sw_prog_halt: assert property (p_sw_prog_halt)
        else $error("Software mode hit did not take program halt path.");

    property p_uaddr_delay;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (s_reg.ucount_run && s_reg.ucount == 2'h0) |=> MHALT_OUT;
    endproperty
    a_uaddr_delay: assert property (p_uaddr_delay)
        else $error("Microaddress stop did not microhalt.");

    property p_toggle_off;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        (wr_cmd && req_type != bpstep_pkg::BP_NONE
            && req_type == s_reg.bp_type
            && !(WR_IN && ADDR_IN == bpstep_pkg::OFS_MODE))
            |=> s_reg.bp_type == bpstep_pkg::BP_NONE;
    endproperty
    a_toggle_off: assert property (p_toggle_off)
        else $error("Reissued breakpoint type did not disable.");
endmodule

// *** sim/cpu_model.sv ***
// Behavioural model of the CPU side that answers microhalt requests.
`timescale 1ns/100ps
module cpu_model (
    input wire logic clk_in,
    input wire logic mhalt_req_in,
    output logic mhalt_out
);
    // The CPU settles into microhalt one major cycle after the request.
    // One run toggle may leave a long interruptible instruction unfinished,
    // so the bench issues program steps again.
    always_ff @(posedge clk_in) begin
        mhalt_out <= mhalt_req_in;
    end
endmodule

// *** sim/cpu_breakpoint_step_control_bench.sv ***
// Self-checking bench for the breakpoint and step unit.
`timescale 1ns/100ps
module cpu_breakpoint_step_control_bench;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
    logic mrd = 1'b0, mwr = 1'b0, cpu_mh, mhalt, fv, tog, ustep;
    logic ird = 1'b0, iwr = 1'b0, uv = 1'b0, tfail = 1'b0, sh, sup;
    logic [15:0] uaddr = 16'h0000;
    logic [15:0] addr = 16'h0000, bus_addr = 16'h0000, fuw;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [63:0] ext;
    int bad_count = 0, n_tests = 0, cycles = 0;
    always #2.5 clk = ~clk;
    cpu_breakpoint_step_control dut (.CLK_IN(clk), .RST_B_IN(rst_b),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .CPU_RUN_IN(run), .CPU_MHALT_IN(cpu_mh),
        .UADDR_IN(uaddr), .UADDR_VALID_IN(uv), .BUS_ADDR_IN(bus_addr),
        .MEM_RD_IN(mrd), .MEM_WR_IN(mwr), .IO_RD_IN(ird), .IO_WR_IN(iwr),
        .TEST_FAIL_IN(tfail), .MHALT_OUT(mhalt), .FORCE_UINSTR_OUT(fuw),
        .FORCE_VALID_OUT(fv), .TOGGLE_RUN_OUT(tog), .SET_HALT_OUT(sh),
        .USTEP_OUT(ustep), .TIMER_SUPPRESS_OUT(sup), .EXT_REGS_OUT(ext));
    cpu_model cpu (.clk_in(clk), .mhalt_req_in(mhalt), .mhalt_out(cpu_mh));
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task access(input logic [3:0] m);
        @(posedge clk);
        {ird, iwr, mrd, mwr} <= m;
        @(posedge clk);
        {ird, iwr, mrd, mwr} <= 4'h0;
        #1;
    endtask
    task t_step;
        int i;
        i = 0;
        wr_reg(16'h0000, 32'h1);
        check(mhalt, 1'b1);
        while (fv !== 1'b1 && i < 20) begin
            tick();
            i++;
        end
        check(fuw, 16'h0401);
        tick();
        check({fv, fuw}, {1'b1, 16'h0201});
        tick();
        check(tog, 1'b1);
        tick();
        check(mhalt, 1'b0);
        @(posedge clk) run <= 1'b1;
        wr_reg(16'h0000, 32'h1);
        tick();
        check(mhalt, 1'b0);
        @(posedge clk) run <= 1'b0;
        wr_reg(16'h0000, 32'h1);
        check(mhalt, 1'b1);
        repeat (8) @(posedge clk);
    endtask
    task t_break;
        wr_reg(16'h0008, 32'h1234);
        wr_reg(16'h0000, 32'h200);
        rd_reg(16'h000C);
        check(d[5:0], 6'h22);
        @(posedge clk) bus_addr <= 16'h1234;
        access(4'h1);
        check(mhalt, 1'b0);
        // A read may be a prefetch of a path never taken; it still hits.
        access(4'h2);
        check(mhalt, 1'b1);
        wr_reg(16'h0000, 32'h1);
        rd_reg(16'h000C);
        check(d[7:6], 2'b10);
        wr_reg(16'h0000, 32'h2);
        check(ustep, 1'b0);
        wr_reg(16'h0004, 32'h0);
        wr_reg(16'h0000, 32'h2);
        check({ustep, sup}, 2'b11);
        wr_reg(16'h0000, 32'h200);
        rd_reg(16'h000C);
        check(d[2:0], 3'h0);
        wr_reg(16'h0000, 32'h18);
        check({sh, mhalt}, 2'b10);
    endtask
    task t_uaddr;
        wr_reg(16'h0000, 32'h100);
        @(posedge clk);
        uaddr <= 16'h1234;
        uv <= 1'b1;
        @(posedge clk) uaddr <= 16'h0000;
        repeat (3) @(posedge clk);
        uv <= 1'b0;
        #1 check(mhalt, 1'b0);
        tick();
        check({mhalt, sup}, 2'b11);
    endtask
    task t_sw;
        wr_reg(16'h0000, 32'h8);
        wr_reg(16'h0004, 32'h1);
        rd_reg(16'h000C);
        check(d[2:0], 3'h0);
        wr_reg(16'h0000, 32'h100);
        rd_reg(16'h000C);
        check(d[2:0], 3'h0);
        wr_reg(16'h0000, 32'h400);
        access(4'h8);
        check(sh, 1'b0);
        access(4'h4);
        check({sh, mhalt}, 2'b10);
    endtask
    task t_fail;
        wr_reg(16'h3C00, 32'h1111);
        wr_reg(16'h0010, 32'h17);
        wr_reg(16'h0014, 32'h1);
        repeat (260) @(posedge clk);
        rd_reg(16'h3C00);
        check(d, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr_reg(16'h2000, k ? 32'h2222 : 32'hBEEF);
            @(posedge clk) tfail <= 1'b1;
            @(posedge clk) tfail <= 1'b0;
            repeat (520) @(posedge clk);
            rd_reg(16'h3C00);
            check(d, 32'hBEEF);
        end
    endtask
    task t_ext;
        wr_reg(16'h0010, 32'h17);
        wr_reg(16'h002C, 32'hA5);
        check(ext[31:24], 8'hA5);
        wr_reg(16'h0030, 32'h5A);
        check(ext[39:32], 8'h00);
        rd_reg(16'h0018);
        check(d, 32'hA5000000);
        rd_reg(16'h0100);
        check(d, 32'h0);
    endtask
    task stop_test;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hung wait short well after the tests should have ended.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(16'h0004);
        check(d, 32'h2);
        t_step();
        t_break();
        t_ext();
        t_uaddr();
        t_sw();
        t_fail();
        stop_test();
    end
endmodule
